// File: src/bsor_regs.sv
// Status, current readback, lock, soft-start and per-phase overcurrent
// registers of a multiphase buck controller.
// Assumes an I2C slave engine on clk giving one-cycle byte read and write
// strobes; enable, straps and comparators arrive asynchronously.
`timescale 1ns/1ns
`default_nettype none
`include "bsor_params.svh"

module bsor_regs #(
    parameter bsor_pkg::bsor_cnt_t DLY0_CYC =
        18'(`BSOR_DLY0_US * `BSOR_CLK_MHZ),
    parameter bsor_pkg::bsor_cnt_t DLY1_CYC =
        18'(`BSOR_DLY1_US * `BSOR_CLK_MHZ),
    parameter bsor_pkg::bsor_cnt_t DLY2_CYC =
        18'(`BSOR_DLY2_US * `BSOR_CLK_MHZ),
    parameter bsor_pkg::bsor_cnt_t DLY3_CYC =
        18'(`BSOR_DLY3_US * `BSOR_CLK_MHZ)
) (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic [7:0]                  reg_addr,
    input  wire logic                        reg_wr,
    input  wire logic [7:0]                  reg_wdata,
    input  wire logic                        reg_rd,
    output var  logic [7:0]                  reg_rdata,
    input  wire logic                        enable,
    input  wire logic [7:0]                  measured_current_value,
    input  wire logic [7:0]                  current_warning_threshold,
    input  wire logic                        override_a,
    input  wire logic                        override_b,
    input  wire logic [3:0]                  ramp_strap_code,
    input  wire logic [3:0]                  overcurrent_strap_pin,
    input  wire logic                        reference_low,
    input  wire logic [`BSOR_NUM_PHASES-1:0] phase_overcurrent,
    output var  logic                        alert,
    output var  logic [9:0]                  ramp_time_10us,
    output var  logic [1:0]                  phase_current_threshold_code,
    output var  logic [1:0]                  shutdown_delay_code,
    output var  logic                        regulator_latch_off
);
    // Two-stage synchronisers for everything arriving from pins
    logic [`BSOR_NUM_PHASES+9:0] sync1_q;
    logic [`BSOR_NUM_PHASES+9:0] sync2_q;
    logic                        en_prev_q;
    logic                        en_s;
    logic                        ref_low_s;
    logic [3:0]                  ramp_strap_s;
    logic [3:0]                  oc_strap_s;
    logic [`BSOR_NUM_PHASES-1:0] phase_oc_s;

    logic                        warn_q;
    logic                        alert_q;
    bsor_pkg::bsor_byte_t        current_q;
    logic                        lock_q;
    bsor_pkg::bsor_nib_t         ramp_code_q;
    bsor_pkg::bsor_nib_t         oc_status_q;
    bsor_pkg::bsor_nib_t         oc_config_q;
    bsor_pkg::bsor_ramp_t        ramp_time_q;
    bsor_pkg::bsor_code2_t       thr_q;
    bsor_pkg::bsor_code2_t       dly_q;
    bsor_pkg::bsor_byte_t        rdata_q;

    wire en_rise = en_s && !en_prev_q;
    wire en_fall = !en_s && en_prev_q;
    wire over_threshold = measured_current_value > current_warning_threshold;
    wire wr_lock = reg_wr && (reg_addr == `BSOR_ADDR_LOCK);
    wire wr_config = reg_wr && (reg_addr == `BSOR_ADDR_OC_CONFIG);
    wire override_on = override_a && override_b;

    function automatic bsor_pkg::bsor_ramp_t ramp_time(
        input bsor_pkg::bsor_nib_t code,
        input logic                low_ref
    );
        bsor_pkg::bsor_ramp_t t;
        logic [13:0]          s;
        if (code < `BSOR_RAMP_CODE_1MS)
            t = 10'(({6'h00, code} + 10'd1) * `BSOR_RAMP_STEP_SHORT);
        else if (code == `BSOR_RAMP_CODE_1MS)
            t = `BSOR_RAMP_STEP_LONG;
        else
            t = 10'({6'h00, code - `BSOR_RAMP_LONG_BASE}
                    * `BSOR_RAMP_STEP_LONG);
        s = 14'({4'h0, t} * `BSOR_RAMP_SCALE_NUM / `BSOR_RAMP_SCALE_DEN);
        return low_ref ? s[9:0] : t;
    endfunction

    assign en_s         = sync2_q[0];
    assign ref_low_s    = sync2_q[1];
    assign ramp_strap_s = sync2_q[5:2];
    assign oc_strap_s   = sync2_q[9:6];
    assign phase_oc_s   = sync2_q[`BSOR_NUM_PHASES+9:10];

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_q   <= '0;
            sync2_q   <= '0;
            en_prev_q <= 1'b0;
        end
        else
        begin
            sync1_q   <= {phase_overcurrent, overcurrent_strap_pin,
                          ramp_strap_code, reference_low, enable};
            sync2_q   <= sync1_q;
            en_prev_q <= en_s;
        end
    end

    // cleared only by enable toggle, set wins
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            warn_q <= 1'b0;
        else if (over_threshold)
            warn_q <= 1'b1;
        else if (en_fall)
            warn_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            alert_q   <= 1'b0;
            current_q <= `BSOR_RST_BYTE;
        end
        else
        begin
            alert_q   <= warn_q || over_threshold;
            current_q <= measured_current_value;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            lock_q <= 1'b0;
        else if (wr_lock && reg_wdata[`BSOR_LOCK_BIT])
            lock_q <= 1'b1;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            oc_config_q <= `BSOR_RST_NIB;
        else if (wr_config && !lock_q)
            oc_config_q <= reg_wdata[`BSOR_THR_MSB:`BSOR_DLY_LSB];
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ramp_code_q <= `BSOR_RST_NIB;
            oc_status_q <= `BSOR_RST_NIB;
        end
        else if (en_rise)
        begin
            ramp_code_q <= ramp_strap_s;
            oc_status_q <= oc_strap_s;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ramp_time_q <= '0;
            thr_q       <= `BSOR_RST_CODE2;
            dly_q       <= `BSOR_RST_CODE2;
        end
        else
        begin
            ramp_time_q <= ramp_time(ramp_code_q, ref_low_s);
            thr_q <= override_on ? oc_config_q[`BSOR_THR_MSB:`BSOR_THR_LSB]
                                 : oc_status_q[`BSOR_THR_MSB:`BSOR_THR_LSB];
            dly_q <= override_on ? oc_config_q[`BSOR_DLY_MSB:`BSOR_DLY_LSB]
                                 : oc_status_q[`BSOR_DLY_MSB:`BSOR_DLY_LSB];
        end
    end

    // reserved bits read zero, unmapped reads zero
    wire [7:0] read_mux =
        (reg_addr == `BSOR_ADDR_WARN_STATUS) ? {`BSOR_ZERO7, warn_q} :
        (reg_addr == `BSOR_ADDR_CURRENT)     ? current_q :
        (reg_addr == `BSOR_ADDR_LOCK)        ? {`BSOR_ZERO7, lock_q} :
        (reg_addr == `BSOR_ADDR_RAMP_STATUS) ? {`BSOR_ZERO4, ramp_code_q} :
        (reg_addr == `BSOR_ADDR_OC_STATUS)   ? {`BSOR_ZERO4, oc_status_q} :
        (reg_addr == `BSOR_ADDR_OC_CONFIG)   ? {`BSOR_ZERO4, oc_config_q} :
                                               `BSOR_RST_BYTE;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_q <= `BSOR_RST_BYTE;
        else if (reg_rd)
            rdata_q <= read_mux;
    end

    bsor_latchoff #(
        .DLY0_CYC (DLY0_CYC),
        .DLY1_CYC (DLY1_CYC),
        .DLY2_CYC (DLY2_CYC),
        .DLY3_CYC (DLY3_CYC)
    ) u_latchoff (
        .clk        (clk),
        .reset_n    (reset_n),
        .enable     (en_s),
        .phase_oc   (phase_oc_s),
        .delay_code (dly_q),
        .latch_off  (regulator_latch_off)
    );

    assign reg_rdata                    = rdata_q;
    assign alert                        = alert_q;
    assign ramp_time_10us               = ramp_time_q;
    assign phase_current_threshold_code = thr_q;
    assign shutdown_delay_code          = dly_q;
endmodule // bsor_regs
`default_nettype wire

// File: src/bsor_params.svh
// Register offsets, field positions, reset values and timing constants
// Assumes inclusion by bare name from the design files
`ifndef BSOR_PARAMS_SVH
`define BSOR_PARAMS_SVH

`define BSOR_ADDR_WARN_STATUS  8'h24
`define BSOR_ADDR_CURRENT      8'h26
`define BSOR_ADDR_LOCK         8'h2a
`define BSOR_ADDR_RAMP_STATUS  8'h2b
`define BSOR_ADDR_OC_STATUS    8'h2d
`define BSOR_ADDR_OC_CONFIG    8'h2e

`define BSOR_WARN_BIT          0
`define BSOR_LOCK_BIT          0
`define BSOR_RAMP_MSB          3
`define BSOR_THR_MSB           3
`define BSOR_THR_LSB           2
`define BSOR_DLY_MSB           1
`define BSOR_DLY_LSB           0

`define BSOR_RST_BYTE          8'h00
`define BSOR_RST_NIB           4'h0
`define BSOR_RST_CODE2         2'h0
`define BSOR_ZERO4             4'h0
`define BSOR_ZERO7             7'h00

// Ramp times in units of 10 us at a 1 V reference
`define BSOR_RAMP_STEP_SHORT   10'd15
`define BSOR_RAMP_STEP_LONG    10'd100
`define BSOR_RAMP_CODE_1MS     4'h6
`define BSOR_RAMP_LONG_BASE    4'h5
`define BSOR_RAMP_SCALE_NUM    4
`define BSOR_RAMP_SCALE_DEN    5

// Latch-off delays in microseconds, clock rate in MHz
`define BSOR_CLK_MHZ           25
`define BSOR_DLY0_US           4000
`define BSOR_DLY1_US           6000
`define BSOR_DLY2_US           8000
`define BSOR_DLY3_US           10000
`define BSOR_DLY_CNT_W         18
`define BSOR_NUM_PHASES        4

`endif

// File: src/bsor_pkg.sv
// Shared types of the buck status, overcurrent and soft-start registers
// Assumes nothing beyond a SystemVerilog compiler
package bsor_pkg;
    typedef logic [7:0]  bsor_byte_t;
    typedef logic [3:0]  bsor_nib_t;
    typedef logic [1:0]  bsor_code2_t;
    typedef logic [9:0]  bsor_ramp_t;
    typedef logic [17:0] bsor_cnt_t;
endpackage

// File: src/bsor_latchoff.sv
// Per-phase overcurrent persistence timers and the latch-off flag
// Assumes synchronised per-phase event levels on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "bsor_params.svh"

module bsor_latchoff #(
    parameter bsor_pkg::bsor_cnt_t DLY0_CYC = 18'd100000,
    parameter bsor_pkg::bsor_cnt_t DLY1_CYC = 18'd150000,
    parameter bsor_pkg::bsor_cnt_t DLY2_CYC = 18'd200000,
    parameter bsor_pkg::bsor_cnt_t DLY3_CYC = 18'd250000
) (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic                        enable,
    input  wire logic [`BSOR_NUM_PHASES-1:0] phase_oc,
    input  wire bsor_pkg::bsor_code2_t       delay_code,
    output var  logic                        latch_off
);
    bsor_pkg::bsor_cnt_t cnt_q [`BSOR_NUM_PHASES];
    logic                latch_q;
    logic [`BSOR_NUM_PHASES-1:0] expired;
    bsor_pkg::bsor_cnt_t limit;

    assign limit = (delay_code == 2'h0) ? DLY0_CYC :
                   (delay_code == 2'h1) ? DLY1_CYC :
                   (delay_code == 2'h2) ? DLY2_CYC : DLY3_CYC;

    // each phase timed on its own
    genvar g;
    generate
        for (g = 0; g < `BSOR_NUM_PHASES; g++)
        begin : g_phase
            assign expired[g] = phase_oc[g] && (cnt_q[g] >= limit - 18'd1);
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    cnt_q[g] <= '0;
                else if (!phase_oc[g] || !enable)
                    cnt_q[g] <= '0;
                else if (!expired[g])
                    cnt_q[g] <= cnt_q[g] + 18'd1;
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            latch_q <= 1'b0;
        else if (!enable)
            latch_q <= 1'b0;
        else if (|expired)
            latch_q <= 1'b1;
    end

    assign latch_off = latch_q;
endmodule // bsor_latchoff
`default_nettype wire

// File: test/bsor_host.sv
// Host model issuing byte register reads and writes
// Assumes strobes are taken on the rising edge of clk
`timescale 1ns/1ns
`default_nettype none
module bsor_host (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic       override_a,
    output var  logic       override_b
);
    initial
    begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {override_a, override_b} = 2'h0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        // Released lines never keep a stale value that could pass by luck
        {reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        {reg_addr, reg_rd} <= {~a, 1'b0};
        @(posedge clk);
        d = reg_rdata;
    endtask
    task automatic ovr(input logic [1:0] v);
        @(posedge clk);
        {override_a, override_b} <= v;
    endtask
endmodule // bsor_host
`default_nettype wire

// File: test/bsor_regs_chk.sv
// Port-level assertions for the register slice
// Assumes it is bound into bsor_regs, one clock domain
`timescale 1ns/1ns
`default_nettype none
module bsor_regs_chk #(
    parameter bsor_pkg::bsor_cnt_t DLY0_CYC = 18'h14
) (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       enable,
    input wire logic [7:0] measured_current_value,
    input wire logic [7:0] current_warning_threshold,
    input wire logic       override_a,
    input wire logic [3:0] phase_overcurrent,
    input wire logic       alert,
    input wire logic [1:0] phase_current_threshold_code,
    input wire logic       regulator_latch_off
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic over = measured_current_value > current_warning_threshold;
    wire logic any_oc = |phase_overcurrent;
    sequence en_steady;
        enable [*8];
    endsequence
    chk_alert_sets:
    assert property (over |-> ##2 alert) else $error("alert late");
    chk_alert_sticky:
    assert property (en_steady ##0 alert |=> alert)
        else $error("alert dropped with enable steady");
    chk_unmapped_zero:
    assert property (reg_rd && !(reg_addr inside {8'h24, 8'h26, 8'h2a,
        8'h2b, 8'h2d, 8'h2e}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_reserved_zero:
    assert property (reg_rd && reg_addr != 8'h26 |=> reg_rdata[7:4] == 4'h0)
        else $error("reserved bits not zero");
    chk_readback_value:
    assert property (reg_rd && reg_addr == 8'h26 &&
        $stable(measured_current_value)
        |=> reg_rdata == $past(measured_current_value))
        else $error("current readback wrong");
    chk_config_ignored:
    assert property ((enable && !override_a) [*8] ##0 reg_wr
        |=> $stable(phase_current_threshold_code))
        else $error("config applied without override");
    chk_latch_delay:
    assert property ($rose(regulator_latch_off) |-> $past(any_oc, DLY0_CYC))
        else $error("latch-off too early");
    chk_latch_clears:
    assert property ((!enable) [*4] |-> !regulator_latch_off)
        else $error("latch-off held while disabled");
endmodule // bsor_regs_chk

bind bsor_regs bsor_regs_chk #(
    .DLY0_CYC (DLY0_CYC)
) u_chk (
    .clk                          (clk),
    .reset_n                      (reset_n),
    .reg_addr                     (reg_addr),
    .reg_wr                       (reg_wr),
    .reg_rd                       (reg_rd),
    .reg_rdata                    (reg_rdata),
    .enable                       (enable),
    .measured_current_value       (measured_current_value),
    .current_warning_threshold    (current_warning_threshold),
    .override_a                   (override_a),
    .phase_overcurrent            (phase_overcurrent),
    .alert                        (alert),
    .phase_current_threshold_code (phase_current_threshold_code),
    .regulator_latch_off          (regulator_latch_off)
);
`default_nettype wire

// File: test/bsor_regs_tb_top.sv
// Bench driving the register slice through its byte strobes
// Assumes the host model and the bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module bsor_regs_tb_top;
    logic       clk, reset_n, enable, reference_low, wr, rd, ovr_a, ovr_b;
    logic       alert, latch;
    logic [7:0] addr, wdata, rdata, mcv, thr;
    logic [3:0] ramp_code, oc_strap, phase_oc;
    logic [9:0] ramp_t;
    logic [1:0] thr_code, dly_code;
    int         err_total, total_checks;
    logic [7:0] map [8] = '{8'h24, 8'h25, 8'h26, 8'h2a, 8'h2b, 8'h2c,
                            8'h2d, 8'h2e};
    bsor_host host (.clk(clk), .reg_rdata(rdata), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .override_a(ovr_a),
        .override_b(ovr_b));
    // Short latch-off counts keep the run brief; codes 1 and 3 keep their
    // full counts and are only checked as decoded values
    bsor_regs #(.DLY0_CYC(18'h14), .DLY2_CYC(18'h28)) dut (.clk(clk),
        .reset_n(reset_n),
        .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
        .reg_rdata(rdata), .enable(enable), .measured_current_value(mcv),
        .current_warning_threshold(thr), .override_a(ovr_a),
        .override_b(ovr_b), .ramp_strap_code(ramp_code),
        .overcurrent_strap_pin(oc_strap), .reference_low(reference_low),
        .phase_overcurrent(phase_oc), .alert(alert), .ramp_time_10us(ramp_t),
        .phase_current_threshold_code(thr_code),
        .shutdown_delay_code(dly_code), .regulator_latch_off(latch));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        host.rd(a, v);
        chk({2'h0, v}, {2'h0, e});
    endtask
    // Ends just after an edge so outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic en_pulse;
        @(posedge clk);
        enable <= 1'b0;
        cyc(6);
        enable <= 1'b1;
        cyc(6);
    endtask
    function automatic logic [9:0] ramp_exp(input int c, input logic lo);
        int t;
        t = c < 6 ? 15 * (c + 1) : (c == 6 ? 100 : (c - 5) * 100);
        return lo ? 10'(t * 4 / 5) : 10'(t);
    endfunction
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        {reset_n, enable, reference_low, mcv, thr} = '0;
        {ramp_code, oc_strap, phase_oc} = '0;
        {err_total, total_checks} = '0;
        cyc(5);
        reset_n <= 1'b1;
        foreach (map[i]) rc(map[i], 8'h00);
        for (int i = 0; i < 32; i++)
        begin
            {reference_low, ramp_code, oc_strap} <= {i[4], i[3:0], ~i[3:0]};
            en_pulse;
            rc(8'h2b, {4'h0, i[3:0]});
            rc(8'h2d, {4'h0, ~i[3:0]});
            chk(ramp_t, ramp_exp(i % 16, i[4]));
            chk({8'h0, thr_code}, {8'h0, ~i[3:2]});
            chk({8'h0, dly_code}, {8'h0, ~i[1:0]});
        end
        {thr, mcv} <= {8'h80, 8'h80};
        cyc(4);
        rc(8'h24, 8'h00);
        mcv <= 8'h81;
        cyc(4);
        mcv <= 8'h00;
        chk({9'h0, alert}, 10'h1);
        rc(8'h24, 8'h01);
        host.wr(8'h24, 8'h00);
        rc(8'h24, 8'h01);
        en_pulse;
        rc(8'h24, 8'h00);
        chk({9'h0, alert}, 10'h0);
        {thr, mcv} <= {8'hff, 8'hff};
        rc(8'h26, 8'hff);
        mcv <= 8'h5a;
        rc(8'h26, 8'h5a);
        host.wr(8'h2e, 8'hf6);
        rc(8'h2e, 8'h06);
        host.ovr(2'b10);
        cyc(3);
        chk({6'h0, thr_code, dly_code}, 10'h0);
        host.ovr(2'b11);
        cyc(3);
        chk({6'h0, thr_code, dly_code}, 10'h6);
        phase_oc <= 4'h4;
        cyc(36);
        chk({9'h0, latch}, 10'h0);
        cyc(10);
        chk({9'h0, latch}, 10'h1);
        phase_oc <= 4'h0;
        en_pulse;
        chk({9'h0, latch}, 10'h0);
        // Two phases in turn; the first stays shorter than the code 0 delay, the second is held until it latches
        host.wr(8'h2e, 8'h0c);
        phase_oc <= 4'h1;
        cyc(15);
        chk({6'h0, thr_code, dly_code}, 10'hc);
        phase_oc <= 4'h2;
        cyc(15);
        chk({9'h0, latch}, 10'h0);
        cyc(10);
        chk({9'h0, latch}, 10'h1);
        phase_oc <= 4'h0;
        en_pulse;
        chk({9'h0, latch}, 10'h0);
        host.wr(8'h2a, 8'hff);
        rc(8'h2a, 8'h01);
        host.wr(8'h2a, 8'h00);
        rc(8'h2a, 8'h01);
        host.wr(8'h2e, 8'h09);
        rc(8'h2e, 8'h0c);
        host.wr(8'h2b, 8'h05);
        rc(8'h2b, 8'h0f);
        reset_n <= 1'b0;
        cyc(5);
        reset_n <= 1'b1;
        rc(8'h2a, 8'h00);
        close_out;
    end
    initial
    begin
        cyc(4000);
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out;
    end
endmodule // bsor_regs_tb_top
`default_nettype wire
